/* rtl/bmvc_phase.sv */
// one buck channel switching sequencer: high side, low side, idle
// assumes all inputs are already synchronous to ref_clk_i
`timescale 1ns/1ns
`default_nettype none
module bmvc_phase (
  input  wire logic ref_clk_i,   // reference clock
  input  wire logic rst_n_i,     // synchronous reset, active low
  input  wire logic run_i,       // channel running
  input  wire logic tick_i,      // oscillator period start, one cycle
  input  wire logic fixed_i,     // forced fixed-frequency mode
  input  wire logic peak_i,      // peak current reached
  input  wire logic below_i,     // output below regulation
  input  wire logic light_i,     // light load
  input  wire logic zero_i,      // inductor current at zero
  output logic      hs_o,        // high-side gate
  output logic      ls_o         // low-side gate
);
  import bmvc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bmvc_phase_t state_q, state_d;   // switching phase
  logic        active;             // a new period may start
  logic        hs_q, ls_q;         // registered gates

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    // bursts only while below regulation at light load in auto mode
    active  = fixed_i | ~light_i | below_i;
    state_d = state_q;
    if (!run_i) begin
      state_d = BMVC_OFF;
    end else begin
      unique case (state_q)
        BMVC_OFF: begin
          if (tick_i && active) state_d = BMVC_HS;
        end
        BMVC_HS: begin
          if (peak_i) state_d = BMVC_LS;
        end
        BMVC_LS: begin
          if (tick_i && active) begin
            state_d = BMVC_HS;
          end else if (zero_i && !fixed_i) begin
            state_d = BMVC_OFF;
          end
          // forced mode keeps the low side on through zero current
        end
        default: state_d = BMVC_OFF;
      endcase
    end
  end

  // registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= BMVC_OFF;
      hs_q    <= 1'b0;
      ls_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      hs_q    <= (state_d == BMVC_HS);
      ls_q    <= (state_d == BMVC_LS);
    end
  end

  assign hs_o = hs_q;
  assign ls_o = ls_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_start;
    run_i && tick_i && (fixed_i || !light_i || below_i) && state_q != BMVC_HS;
  endsequence

  a_period_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_start |=> hs_o && !ls_o) else $error("high side missed the period start");
  a_peak_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    run_i && state_q == BMVC_HS && peak_i |=> !hs_o && ls_o)
    else $error("high side stayed on past peak");
  a_lowside_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    run_i && fixed_i && state_q == BMVC_LS && !tick_i |=> ls_o)
    else $error("low side dropped in forced mode");
  a_zero_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    run_i && !fixed_i && state_q == BMVC_LS && zero_i && !tick_i |=> !ls_o && !hs_o)
    else $error("low side held at zero current in auto mode");
  a_burst_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    run_i && state_q == BMVC_OFF && light_i && !below_i && !fixed_i |=> !hs_o && !ls_o)
    else $error("switching while idle between bursts");
  a_no_overlap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(hs_o && ls_o)) else $error("both transistors on");
endmodule : bmvc_phase
`default_nettype wire

/* rtl/bmvc_pkg.sv */
// package of constants, types and carriers for the buck mode and voltage control
// assumes a single 20 MHz reference clock and a synchronous active-low reset
package bmvc_pkg;
  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int NCH           = 4;       // buck channels
  localparam int CODE_W        = 5;       // voltage code width
  localparam int MV_W          = 13;      // target voltage in millivolts
  localparam int CLK_PERIOD_NS = 50;      // ref_clk_i period
  localparam int STEP_BASE_NS  = 62500;   // shortest scaling step interval
  localparam int STEP_BASE_CYC = STEP_BASE_NS / CLK_PERIOD_NS;
  localparam int OSC_PERIOD_CYC = 33;     // internal oscillator period in clocks
  localparam int TMR_W         = 16;      // step timer width

  // ----------------------------------------------------------------
  // reset values and voltage code tables
  // ----------------------------------------------------------------
  localparam logic [3:0] CH_ON_RST  = 4'hf;  // enable bits default to one
  localparam int CH1_BASE_MV = 850;
  localparam int CH1_STEP_MV = 25;
  localparam int CH1_MAX_CODE = 30;
  localparam int CH2_BASE_MV = 3300;
  localparam int CH2_STEP_MV = 300;
  localparam int CH2_KNEE_CODE = 6;       // from here the last 200 mV step
  localparam int CH2_TOP_MV  = 5000;
  localparam int CH3_BASE_MV = 1200;
  localparam int CH3_STEP_MV = 100;
  localparam int CH3_MAX_CODE = 6;
  localparam int CH4_BASE_MV = 2500;
  localparam int CH4_STEP_MV = 100;
  localparam int CH4_MAX_CODE = 30;
  localparam int SCALE_CH_A  = 0;         // first channel
  localparam int SCALE_CH_B  = 3;         // fourth channel

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BMVC_PIN_LEVEL   = 2'h0,   // mode pin is a plain level
    BMVC_PIN_CLK_IN  = 2'h1,   // mode pin carries an external clock
    BMVC_PIN_CLK_OUT = 2'h2    // mode pin drives a clock out
  } bmvc_pincfg_t;

  typedef enum logic [2:0] {
    BMVC_OFF = 3'b001,         // both transistors off
    BMVC_HS  = 3'b010,         // high side on
    BMVC_LS  = 3'b100          // low side on
  } bmvc_phase_t;

  typedef struct packed {
    logic [NCH-1:0] peak;      // current passed the peak threshold
    logic [NCH-1:0] below;     // output below regulation
    logic [NCH-1:0] light;     // average load below mode threshold
    logic [NCH-1:0] zero;      // inductor current reached zero
  } bmvc_sense_t;

  typedef struct packed {
    logic [NCH-1:0] overvolt;  // overvoltage comparator
    logic [NCH-1:0] short_c;   // short circuit comparator
  } bmvc_fault_t;

  typedef struct packed {
    logic       en;            // scaling enable
    logic [1:0] interval;      // step interval, base times two to this
  } bmvc_vscale_cfg_t;
endpackage : bmvc_pkg

/* rtl/bmvc_top.sv */
// mode selection, voltage codes, scaling and protection masking for four bucks
// assumes configuration inputs come from host logic on ref_clk_i; pins are async
//
// How it works
// - high side on each period, off at peak
// - low side conducts until next oscillator pulse, or until zero current in auto mode
// - power save: bursts while below regulation, else idle
// - forced mode: constant frequency, low side stays on
// - auto mode: low side off at zero current
// - mode changes apply live without restart
// - pin high or clock: power save bit picks mode
// - pin low: every channel not in a scaling transition runs auto mode
// - each channel target chosen by its code
// - first channel 0.85 V to 1.6 V, 25 mV
// - second channel 3.3 V to 5.0 V, 300/200 mV
// - third channel 1.2 V to 1.8 V, 100 mV
// - fourth channel 2.5 V to 5.5 V, 100 mV
// - scaling on first and fourth, enable plus interval
// - scaling off: new code applies at once
// - scaling forces fixed mode, masks protection latches
// - run needs pin and bit; pin low sets bit
`timescale 1ns/1ns
`default_nettype none
module bmvc_top #(
  parameter int STEP_CYC = bmvc_pkg::STEP_BASE_CYC,  // clocks per base step interval
  parameter int OSC_CYC  = bmvc_pkg::OSC_PERIOD_CYC  // clocks per oscillator period
) (
  input  wire logic                          ref_clk_i,         // reference clock
  input  wire logic                          rst_n_i,           // sync reset, active low
  input  wire logic                          mode_pin_i,        // mode / clock pin level
  input  wire bmvc_pkg::bmvc_pincfg_t        pin_cfg_i,         // mode pin use
  input  wire logic [bmvc_pkg::NCH-1:0]      en_pin_i,          // channel enable pins
  input  wire logic                          ch_on_wr_i,        // enable bit write strobe
  input  wire logic [bmvc_pkg::NCH-1:0]      ch_on_data_i,      // enable bit write data
  input  wire logic [bmvc_pkg::NCH-1:0]      power_save_bit_i,  // power save enable bits
  input  wire logic [bmvc_pkg::NCH-1:0][bmvc_pkg::CODE_W-1:0] voltage_code_i, // codes
  input  wire bmvc_pkg::bmvc_vscale_cfg_t    vscale_cfg_i,      // scaling config
  input  wire bmvc_pkg::bmvc_sense_t         sense_i,           // analog comparators
  input  wire bmvc_pkg::bmvc_fault_t         fault_i,           // protection comparators
  output logic [bmvc_pkg::NCH-1:0]           hs_gate_o,         // high-side gates
  output logic [bmvc_pkg::NCH-1:0]           ls_gate_o,         // low-side gates
  output logic [bmvc_pkg::NCH-1:0]           ch_run_o,          // channel running
  output logic [bmvc_pkg::NCH-1:0]           channel_enable_bit_o, // stored enable bits
  output logic [bmvc_pkg::NCH-1:0]           fixed_mode_o,      // forced mode in effect
  output logic [1:0]                         vscale_busy_o,     // scaling in progress
  output logic [bmvc_pkg::NCH-1:0][bmvc_pkg::MV_W-1:0] target_mv_o, // targets in mV
  output logic [bmvc_pkg::NCH-1:0]           fault_latch_o,     // latched-off channels
  output logic [bmvc_pkg::NCH-1:0]           hiccup_o           // hiccup request level
);
  import bmvc_pkg::*;

  localparam int SYNC_W = 1 + NCH + $bits(bmvc_sense_t) + $bits(bmvc_fault_t);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] s1_q, s2_q;     // two-stage synchroniser
  logic              mode_s;         // synced mode pin
  logic              mode_d1_q;      // previous synced mode pin, edge detect
  logic [NCH-1:0]    en_s;           // synced enable pins
  bmvc_sense_t       sense_s;        // synced comparators
  bmvc_fault_t       fault_s;        // synced protection inputs

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      // mode bit rests high like its pulled-up pin, so release makes no false edge
      s1_q      <= {1'b1, {(SYNC_W-1){1'b0}}};
      s2_q      <= {1'b1, {(SYNC_W-1){1'b0}}};
      mode_d1_q <= 1'b1;
    end else begin
      s1_q      <= {mode_pin_i, en_pin_i, sense_i, fault_i};
      s2_q      <= s1_q;
      mode_d1_q <= mode_s;
    end
  end

  assign {mode_s, en_s, sense_s, fault_s} = s2_q;

  // ----------------------------------------------------------------
  // oscillator tick: internal divider or external clock edge
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] osc_q, osc_d;    // internal period counter
  logic             tick_q, tick_d;  // period start pulse

  always_comb begin
    osc_d  = (osc_q >= TMR_W'(OSC_CYC - 1)) ? '0 : osc_q + 1'b1;
    // an external clock on the pin paces switching instead of the divider
    if (pin_cfg_i == BMVC_PIN_CLK_IN) begin
      tick_d = mode_s & ~mode_d1_q;
    end else begin
      tick_d = (osc_q == '0);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      osc_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      osc_q  <= osc_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------------------------------
  // channel enable bits
  // ----------------------------------------------------------------
  logic [NCH-1:0] on_q, on_d;        // stored enable bits
  logic [NCH-1:0] run_q, run_d;      // pin and bit both high

  always_comb begin
    on_d = ch_on_wr_i ? ch_on_data_i : on_q;
    // a low pin resets the channel and restores its bit
    on_d  = on_d | ~en_s;
    run_d = en_s & on_d;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      on_q  <= CH_ON_RST;
      run_q <= '0;
    end else begin
      on_q  <= on_d;
      run_q <= run_d;
    end
  end

  // ----------------------------------------------------------------
  // voltage scaling on the first and fourth channels
  // ----------------------------------------------------------------
  logic [1:0][CODE_W-1:0] eff_q, eff_d;    // effective codes being stepped
  logic [1:0][TMR_W-1:0]  tmr_q, tmr_d;    // step interval timers
  logic [1:0]             busy_q, busy_d;  // transition in progress
  logic [TMR_W-1:0]       step_len;        // clocks per step
  logic [1:0][CODE_W-1:0] tgt;             // requested codes

  always_comb begin
    step_len = TMR_W'(STEP_CYC << vscale_cfg_i.interval);
    tgt[0]   = voltage_code_i[SCALE_CH_A];
    tgt[1]   = voltage_code_i[SCALE_CH_B];
    for (int k = 0; k < 2; k++) begin
      eff_d[k] = eff_q[k];
      // the timer restarts after every step, so each step waits a full interval
      tmr_d[k] = '0;
      if (!vscale_cfg_i.en) begin
        eff_d[k] = tgt[k];
      end else if (eff_q[k] != tgt[k]) begin
        if (tmr_q[k] >= step_len - 1'b1) begin
          // one code toward the target per interval
          eff_d[k] = (eff_q[k] < tgt[k]) ? eff_q[k] + 1'b1 : eff_q[k] - 1'b1;
        end else begin
          tmr_d[k] = tmr_q[k] + 1'b1;
        end
      end
      busy_d[k] = vscale_cfg_i.en && (eff_d[k] != tgt[k]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      eff_q  <= '0;
      tmr_q  <= '0;
      busy_q <= '0;
    end else begin
      eff_q  <= eff_d;
      tmr_q  <= tmr_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // mode selection, targets and protection masking
  // ----------------------------------------------------------------
  logic [NCH-1:0]            mask;             // protection masked, fixed mode forced
  logic                      follow_bits;      // power save bits decide the mode
  logic [NCH-1:0]            fixed_q, fixed_d; // forced fixed-frequency per channel
  logic [NCH-1:0][MV_W-1:0]  mv_q, mv_d;       // targets in millivolts
  logic [NCH-1:0][CODE_W-1:0] code_eff;        // code in effect
  logic [NCH-1:0]            latch_q, latch_d; // latched-off channels
  logic [NCH-1:0]            hic_q, hic_d;     // hiccup requests

  // clamp a code to its range and scale it
  function automatic logic [MV_W-1:0] mv_of(input int base, input int step,
                                            input int maxc, input logic [CODE_W-1:0] c);
    int n;
    n = (int'(c) > maxc) ? maxc : int'(c);
    mv_of = MV_W'(base + step * n);
  endfunction : mv_of

  always_comb begin
    mask        = '0;
    mask[SCALE_CH_A] = busy_q[0];
    mask[SCALE_CH_B] = busy_q[1];
    // a level high, or any clock use of the pin, lets the bits rule
    follow_bits = mode_s | (pin_cfg_i != BMVC_PIN_LEVEL);
    // low level: all auto except channels in a scaling transition; live mode changes need no restart
    fixed_d     = (follow_bits ? ~power_save_bit_i : '0) | mask;
    code_eff    = voltage_code_i;
    code_eff[SCALE_CH_A] = eff_q[0];
    code_eff[SCALE_CH_B] = eff_q[1];
    mv_d[0] = mv_of(CH1_BASE_MV, CH1_STEP_MV, CH1_MAX_CODE, code_eff[0]);
    if (int'(code_eff[1]) >= CH2_KNEE_CODE) begin
      mv_d[1] = MV_W'(CH2_TOP_MV);
    end else begin
      mv_d[1] = mv_of(CH2_BASE_MV, CH2_STEP_MV, CH2_KNEE_CODE, code_eff[1]);
    end
    mv_d[2] = mv_of(CH3_BASE_MV, CH3_STEP_MV, CH3_MAX_CODE, code_eff[2]);
    mv_d[3] = mv_of(CH4_BASE_MV, CH4_STEP_MV, CH4_MAX_CODE, code_eff[3]);
    // latch-off and hiccup held back during a scaling transition
    hic_d   = fault_s.short_c & run_q & ~mask;
    // a latch holds until its channel stops running
    latch_d = (latch_q & run_q) | ((fault_s.overvolt | fault_s.short_c) & run_q & ~mask);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fixed_q <= '0;
      mv_q    <= '0;
      latch_q <= '0;
      hic_q   <= '0;
    end else begin
      fixed_q <= fixed_d;
      mv_q    <= mv_d;
      latch_q <= latch_d;
      hic_q   <= hic_d;
    end
  end

  // ----------------------------------------------------------------
  // per-channel switching sequencers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    bmvc_phase u_phase (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .run_i     (run_q[i] & ~latch_q[i]),
      .tick_i    (tick_q),
      .fixed_i   (fixed_q[i]),
      .peak_i    (sense_s.peak[i]),
      .below_i   (sense_s.below[i]),
      .light_i   (sense_s.light[i]),
      .zero_i    (sense_s.zero[i]),
      .hs_o      (hs_gate_o[i]),
      .ls_o      (ls_gate_o[i])
    );
  end

  assign ch_run_o             = run_q;
  assign channel_enable_bit_o = on_q;
  assign fixed_mode_o         = fixed_q;
  assign vscale_busy_o        = busy_q;
  assign target_mv_o          = mv_q;
  assign fault_latch_o        = latch_q;
  assign hiccup_o             = hic_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_step_due;
    vscale_cfg_i.en && eff_q[0] != tgt[0] && tmr_q[0] >= step_len - 1'b1;
  endsequence

  a_pin_low_auto: assert property (!mode_s && pin_cfg_i == BMVC_PIN_LEVEL
    && busy_q == '0 |=> fixed_mode_o == '0) else $error("forced mode with mode pin low");
  a_bits_pick: assert property (mode_s && busy_q == '0
    |=> fixed_mode_o == ~$past(power_save_bit_i)) else $error("mode ignores power save bits");
  a_scale_fixed: assert property (vscale_busy_o[1] |=> fixed_mode_o[SCALE_CH_B])
    else $error("scaling channel not in forced mode");
  a_scale_mask: assert property (busy_q[0] |=> !hiccup_o[SCALE_CH_A])
    else $error("hiccup not masked during scaling");
  a_step_one: assert property (s_step_due |=>
    (eff_q[0] == $past(eff_q[0]) + 1'b1) || (eff_q[0] == $past(eff_q[0]) - 1'b1))
    else $error("scaling step not one code");
  a_step_wait: assert property (vscale_cfg_i.en && $changed(eff_q[0]) ##1
    vscale_cfg_i.en |-> $stable(eff_q[0])) else $error("scaling stepped too early");
  a_jump_off: assert property (!vscale_cfg_i.en |=> eff_q[1] == $past(tgt[1]))
    else $error("code not applied at once with scaling off");
  a_pin_resets: assert property (en_s[2] == 1'b0 |=> channel_enable_bit_o[2]
    && !ch_run_o[2]) else $error("enable pin low did not reset channel");
  a_ch3_range: assert property (voltage_code_i[2] == 5'h00 ##1
    voltage_code_i[2] == 5'h00 |=> target_mv_o[2] == MV_W'(CH3_BASE_MV))
    else $error("third channel base voltage wrong");

  // first channel stepping with its latch still open
  sequence s_mask_open;
    busy_q[0] && !fault_latch_o[SCALE_CH_A];
  endsequence

  a_latch_masked: assert property (s_mask_open
    |=> !fault_latch_o[SCALE_CH_A]) else $error("latch-off not masked during scaling");
  a_latch_stops: assert property (fault_latch_o[SCALE_CH_A]
    |=> !hs_gate_o[SCALE_CH_A]) else $error("latched channel still switching");
  a_hiccup_set: assert property (fault_s.short_c[SCALE_CH_A] && run_q[SCALE_CH_A]
    && !busy_q[0] |=> hiccup_o[SCALE_CH_A]) else $error("hiccup missing after scaling");
  a_run_gates: assert property (!ch_run_o[1]
    |=> !hs_gate_o[1] && !ls_gate_o[1]) else $error("stopped channel still switching");
  a_step_hold_b: assert property (vscale_cfg_i.en && eff_q[1] != tgt[1]
    && tmr_q[1] < step_len - 1'b1 |=> $stable(eff_q[1])) else $error("fourth channel stepped early");
endmodule : bmvc_top
`default_nettype wire

/* testbench/bmvc_far_end.sv */
// far-side model: current and load comparators for four buck channels
// assumes gate commands from the block under test on the same clock
`timescale 1ns/1ns
`default_nettype none
module bmvc_far_end (
  input  wire logic             ref_clk_i, // reference clock
  input  wire logic [3:0]       hs_i,      // high-side gates
  input  wire logic [3:0]       ls_i,      // low-side gates
  input  wire logic             light_i,   // light load, all channels
  input  wire logic             below_i,   // output below regulation
  output var bmvc_pkg::bmvc_sense_t sense_o // comparator outputs
);
  import bmvc_pkg::*;
  logic [3:0] hs_q1, hs_q2, ls_q1, ls_q2;  // gate history
  // ------------------------------------------------------------
  // gate history
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    hs_q1 <= hs_i;
    hs_q2 <= hs_q1;
    ls_q1 <= ls_i;
    ls_q2 <= ls_q1;
  end
  // peak after two high-side cycles, zero after two low-side cycles;
  // both drop as soon as the gate opens, as a comparator would
  assign sense_o = {hs_i & hs_q2, {4{below_i}}, {4{light_i}}, ls_i & ls_q2};
endmodule : bmvc_far_end
`default_nettype wire

/* testbench/test_buck_mode_and_voltage_control.sv */
// testbench for the buck mode and voltage control block
// assumes the far-side model file and the design package are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_buck_mode_and_voltage_control;
  import bmvc_pkg::*;
  logic ref_clk_i, rst_n_i, mode_pin_i, ch_on_wr_i, light, below;
  logic [NCH-1:0] en_pin_i, ch_on_data, psb, hs, ls, run, bits, fixed, latch, hic;
  logic [NCH-1:0][CODE_W-1:0] code;       // voltage codes
  logic [NCH-1:0][MV_W-1:0]   mv;         // targets seen
  logic [1:0]                 busy;       // scaling busy
  bmvc_pincfg_t               pin_cfg;    // mode pin use
  bmvc_vscale_cfg_t           vcfg;       // scaling config
  bmvc_sense_t                sense;      // from the far side
  bmvc_fault_t                fault;      // protection comparators
  int error_cnt, checks;
  bmvc_top #(.STEP_CYC(4), .OSC_CYC(16)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .mode_pin_i(mode_pin_i), .pin_cfg_i(pin_cfg), .en_pin_i(en_pin_i),
    .ch_on_wr_i(ch_on_wr_i), .ch_on_data_i(ch_on_data), .power_save_bit_i(psb),
    .voltage_code_i(code), .vscale_cfg_i(vcfg), .sense_i(sense), .fault_i(fault),
    .hs_gate_o(hs), .ls_gate_o(ls), .ch_run_o(run), .channel_enable_bit_o(bits),
    .fixed_mode_o(fixed), .vscale_busy_o(busy), .target_mv_o(mv),
    .fault_latch_o(latch), .hiccup_o(hic));
  bmvc_far_end far (.ref_clk_i(ref_clk_i), .hs_i(hs), .ls_i(ls), .light_i(light),
    .below_i(below), .sense_o(sense));
  // ------------------------------------------------------------
  // clock and shared tasks
  // ------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // wait n falling edges so the outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc
  // bounded wait for a high-side gate level
  task automatic wait_hs(input int ch, input logic v);
    int i;
    for (i = 0; i < 100 && hs[ch] !== v; i++) cyc(1);
    if (i == 100) begin
      error_cnt++;
      test_done();
    end
  endtask : wait_hs
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_enable();
    @(posedge ref_clk_i) en_pin_i <= 4'hf;
    cyc(5);
    chk(run, 4'hf);
    @(posedge ref_clk_i) begin
      ch_on_wr_i <= 1'b1;
      ch_on_data <= 4'hd;
    end
    @(posedge ref_clk_i) ch_on_wr_i <= 1'b0;
    cyc(2);
    chk({bits, run}, 8'hdd);
    @(posedge ref_clk_i) en_pin_i <= 4'hd;
    cyc(5);
    chk({bits, run}, 8'hfd);
    @(posedge ref_clk_i) en_pin_i <= 4'hf;
    cyc(5);
    chk(run, 4'hf);
  endtask : t_enable
  task automatic t_codes();
    logic [NCH-1:0][CODE_W-1:0] c [3];
    logic [NCH-1:0][MV_W-1:0]   e [3];
    c = '{{5'h1e, 5'h6, 5'h5, 5'h1e}, {5'h1f, 5'h7, 5'h6, 5'h1}, {5'h0, 5'h0, 5'h0, 5'h0}};
    e = '{{13'h157c, 13'h708, 13'h12c0, 13'h640}, {13'h157c, 13'h708, 13'h1388, 13'h36b},
          {13'h9c4, 13'h4b0, 13'hce4, 13'h352}};
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk_i) code <= c[k];
      cyc(4);
      chk(mv, e[k]);
    end
  endtask : t_codes
  task automatic t_mode();
    @(posedge ref_clk_i) begin
      psb <= 4'h5;
      mode_pin_i <= 1'b0;
    end
    cyc(5);
    chk(fixed, 4'h0);
    @(posedge ref_clk_i) mode_pin_i <= 1'b1;
    cyc(5);
    chk(fixed, 4'ha);
    @(posedge ref_clk_i) begin
      mode_pin_i <= 1'b0;
      pin_cfg <= BMVC_PIN_CLK_OUT;
    end
    cyc(5);
    chk(fixed, 4'ha);
    @(posedge ref_clk_i) begin
      pin_cfg <= BMVC_PIN_CLK_IN;
      psb <= 4'h3;
    end
    cyc(5);
    chk(fixed, 4'hc);
    @(posedge ref_clk_i) begin
      mode_pin_i <= 1'b1;
      pin_cfg <= BMVC_PIN_LEVEL;
      psb <= 4'h0;
    end
  endtask : t_mode
  task automatic t_switch();
    logic seen;
    cyc(5);
    wait_hs(2, 1'b1);
    wait_hs(2, 1'b0);
    chk(ls[2], 1'b1);
    cyc(6);
    chk({hs[2], ls[2]}, 2'b01);
    @(posedge ref_clk_i) psb <= 4'hf;  // live change to auto mode
    cyc(20);
    seen = 1'b0;
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      seen = seen | hs[2] | ls[2];
    end
    chk(seen, 1'b0);
    @(posedge ref_clk_i) below <= 1'b1;
    wait_hs(2, 1'b1);
    wait_hs(2, 1'b0);
    cyc(7);
    chk({hs[2], ls[2]}, 2'b00);
    @(posedge ref_clk_i) below <= 1'b0;
  endtask : t_switch
  task automatic t_scale();
    @(posedge ref_clk_i) begin
      mode_pin_i <= 1'b0;
      vcfg <= '{en: 1'b1, interval: 2'h0};
    end
    cyc(5);
    chk(fixed[0], 1'b0);
    @(posedge ref_clk_i) begin
      code[0] <= 5'h2;
      code[3] <= 5'h1;
    end
    cyc(4);
    chk({busy, fixed[0], fixed[3], mv[0]}, {4'hf, 13'h352});
    @(posedge ref_clk_i) begin
      fault.overvolt[0] <= 1'b1;
      fault.short_c[0]  <= 1'b1;
    end
    cyc(4);
    chk({latch[0], hic[0]}, 2'b00);
    chk({busy[1], mv[0], mv[3]}, {1'b0, 13'h36b, 13'ha28});
    cyc(4);
    chk({busy[0], mv[0]}, {1'b0, 13'h384});
    cyc(4);
    chk({latch[0], hic[0], fixed[0]}, 3'b110);
    @(posedge ref_clk_i) fault <= '0;
  endtask : t_scale
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {error_cnt, checks} = '0;
    // reset low, no write strobe, light load, output in regulation
    {rst_n_i, ch_on_wr_i, light, below} = 4'h2;
    {en_pin_i, ch_on_data, psb, code, vcfg, fault} = '0;
    mode_pin_i = 1'b1;
    pin_cfg = BMVC_PIN_LEVEL;
    // reset is sampled low at two rising edges
    @(posedge ref_clk_i);
    cyc(1);
    chk({bits, run, hs, ls, fixed, latch, hic, busy}, {4'hf, 26'h0});
    chk(mv, '0);
    @(posedge ref_clk_i) rst_n_i <= 1'b1;
    t_enable();
    t_codes();
    t_mode();
    t_switch();
    t_scale();
    test_done();
  end
endmodule : test_buck_mode_and_voltage_control
`default_nettype wire
